// ### dv/tsa_acq_bench.sv
// self-checking bench for the triggered scan acquisition block
`timescale 1ns/1ns
module tsa_acq_bench import tsa_pkg::*; ;
  localparam int unsigned CW = 6;
  logic            pclk    = 1'b0;
  logic            presetn = 1'b0;
  logic            psel    = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite  = 1'b0;
  logic [7:0]      paddr   = 8'h00;
  logic [31:0]     pwdata  = 32'h0000_0000;
  logic [31:0]     prdata, rd;
  logic            pready, pslverr, scan_req, scan_ack, sync_en, err;
  logic [CW-1:0]   scan_chan;
  logic [3:0]      scan_type;
  logic [15:0]     scan_data;
  int              n_fail, compares;
  logic [7:0]      asc_ex [8] = '{8'h2b, 8'h30, 8'h30, 8'h30, 8'h31, 8'h2e, 8'h30, 8'h2c};
  always #10 pclk = ~pclk;
  tsa_acq_top #(.CW(CW), .TENTH_CYCLES(4)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scan_req(scan_req),
    .scan_chan(scan_chan), .scan_type(scan_type), .scan_ack(scan_ack),
    .scan_data(scan_data), .trig_pin(1'b0), .sync_en(sync_en));
  tsa_conv_model #(.CW(CW)) conv_u (.pclk(pclk), .presetn(presetn), .scan_req(scan_req),
    .scan_chan(scan_chan), .scan_ack(scan_ack), .scan_data(scan_data));
  task automatic wrap_up;
    $display("compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      $display("ERROR %s expected %h seen %h", nm, ex, got);
      n_fail++;
    end
  endtask
  // call just after a rising edge; returns one edge after release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      wrap_up();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, '0);
    chk(nm, ex, rd);
  endtask
  initial begin
    repeat (50000) @(posedge pclk);
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd = '0;
    for (int i = 0; i < 20 && rd[SP_READY] !== 1'b1; i++) apb(1'b0, ADDR_SPOLL, '0);
    rdchk("spoll idle", ADDR_SPOLL, 32'h4);
    rdchk("format", ADDR_FMT, 32'h0);
    apb(1'b0, 8'h34, '0);
    chk("unmapped", 32'h1, 32'(err));
    $display("test reset done");
    apb(1'b1, ADDR_CHAN, 32'h0003_0201);
    apb(1'b1, ADDR_CNT_PRE, 32'h2);
    apb(1'b1, ADDR_CNT_POST, 32'h3);
    apb(1'b1, ADDR_CNT_STOP, 32'h2);
    apb(1'b1, ADDR_IVL_ACQ, 32'h0);
    apb(1'b1, ADDR_IVL_NORM, 32'h0);
    apb(1'b1, ADDR_TRIG, {24'h0, STOP_COUNT, SRC_CHAR});
    apb(1'b1, ADDR_FMT, 32'h1);
    rdchk("pending fmt", ADDR_FMT, 32'h0);
    rdchk("pending cnt", ADDR_CNT_POST, 32'h3);
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_EXEC);
    rdchk("active fmt", ADDR_FMT, 32'h1);
    repeat (40) @(posedge pclk);
    rdchk("armed spoll", ADDR_SPOLL, 32'h4);
    rdchk("pre fill", ADDR_BUFST, 32'd4);
    chk("sync", 32'h0, 32'(sync_en));
    chk("sensor type", 32'h3, 32'(scan_type));
    $display("test arm done");
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_TRIG);
    rdchk("trig spoll", ADDR_SPOLL, 32'h6);
    rd = '0;
    for (int i = 0; i < 60 && rd[EV_ACQ_DONE] !== 1'b1; i++) apb(1'b0, ADDR_EVT, '0);
    chk("acq done", 32'h1, 32'(rd[EV_ACQ_DONE]));
    rdchk("evt cleared", ADDR_EVT, 32'h0);
    rdchk("buf count", ADDR_BUFST, 32'd14);
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_RDBLK);
    for (int i = 0; i < 14; i++) begin
      apb(1'b0, ADDR_DATA, '0);
      chk("reading", (i % 2 == 0) ? 32'd10 : 32'd20, 32'(rd[15:0]));
    end
    rdchk("empty data", ADDR_DATA, 32'h0);
    rdchk("fmt kept", ADDR_FMT, 32'h1);
    $display("test block read done");
    apb(1'b1, ADDR_FMT, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_EXEC);
    rdchk("ascii fmt", ADDR_FMT, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_TRIG);
    rd = '0;
    for (int i = 0; i < 60 && rd[EV_ACQ_DONE] !== 1'b1; i++) apb(1'b0, ADDR_EVT, '0);
    chk("acq done again", 32'h1, 32'(rd[EV_ACQ_DONE]));
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_RDBLK);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ADDR_DATA, '0);
      chk("ascii char", 32'(asc_ex[i]), 32'(rd[7:0]));
    end
    $display("test ascii done");
    wrap_up();
  end
endmodule
bind tsa_acq_top tsa_acq_properties #(.CW(CW)) chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .scan_req(scan_req),
  .scan_chan(scan_chan));

// ### dv/tsa_acq_properties.sv
// port-level checks for the scan acquisition block
`timescale 1ns/1ns
module tsa_acq_properties import tsa_pkg::*; #(
  parameter int unsigned CW = 6
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          scan_req,
  input wire logic [CW-1:0] scan_chan
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pready;
  sequence one_wait; !pready ##1 pready; endsequence
  sequence exec_wr; acc && pwrite && paddr == ADDR_CTRL && pwdata[CTRL_EXEC]; endsequence
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
  ready_wait_a: assert property (psel && $rose(penable) |-> one_wait) else $error("bad wait");
  ready_access_a: assert property (pready |-> psel && penable) else $error("stray pready");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  unmapped_err_a: assert property (acc && (paddr > ADDR_DATA || paddr[1:0] != 2'b00)
    |-> pslverr) else $error("unmapped access not refused");
  err_zero_a: assert property (pslverr && !pwrite |-> prdata == RST_WORD)
    else $error("refused read data not zero");
  exec_scan_a: assert property (exec_wr |-> ##[1:4] scan_req)
    else $error("execute did not start scanning");
  poll_ready_a: assert property (acc && !pwrite && paddr == ADDR_SPOLL |-> prdata[SP_READY])
    else $error("ready bit low");
  chan_based_a: assert property (scan_req |-> scan_chan != '0)
    else $error("channel zero scanned");
endmodule

// ### dv/tsa_conv_model.sv
// converter model: answers each scan request after a fixed delay
`timescale 1ns/1ns
module tsa_conv_model #(
  parameter int unsigned DLY = 2,
  parameter int unsigned CW  = 6
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          scan_req,
  input  wire logic [CW-1:0] scan_chan,
  output logic               scan_ack,
  output logic      [15:0]   scan_data
);
  int unsigned cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r     <= 0;
      scan_ack  <= 1'b0;
      scan_data <= 16'h0000;
    end else if (scan_req && !scan_ack && cnt_r == DLY) begin
      cnt_r     <= 0;
      scan_ack  <= 1'b1;
      scan_data <= 16'(scan_chan) * 16'd10;
    end else begin
      cnt_r     <= (scan_req && !scan_ack) ? cnt_r + 1 : 0;
      scan_ack  <= 1'b0;
      // data is meaningless off the ack cycle, so keep it moving
      scan_data <= ~scan_data;
    end
  end
endmodule

// ### verilog/tsa_acq_top.sv
// command-driven triggered scan acquisition sequencer with apb registers
//
// Functional notes
// - three scan counts: pre, post, post-stop
// - post count used only with count stop
// - post-trigger interval; shared pre/post-stop interval
// - interval given as hours, minutes, seconds, tenths
// - all-zero intervals scan with no delay
// - trigger config: start, stop, rearm, sync
// - start on trigger character; stop on count
// - execute arms and starts pre-trigger scans
// - stay pre-trigger until start event occurs
// - serial poll value 2 after trigger; the register reads 6 here, since the ready bit (4) stays set
// - event status holds acquisition-complete bit
// - binary format returns two-byte values
// - format kept until reset or new format
// - ascii format by default after reset
// - buffer status reports data available
// - status and data readable during acquisition
// - read-oldest returns oldest complete trigger block; here a claim covers all unread complete blocks up to the newest
// - binary reading in tenths of degree
// - channel range gets one sensor type
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module tsa_acq_top import tsa_pkg::*; #(
  parameter int unsigned NCH          = 48,
  parameter int unsigned CW           = 6,
  parameter int unsigned AW           = 10,
  parameter int unsigned TENTH_CYCLES = TENTH_CYC
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  output logic               scan_req,
  output logic      [CW-1:0] scan_chan,
  output logic      [3:0]    scan_type,
  input  wire logic          scan_ack,
  input  wire logic [15:0]   scan_data,
  input  wire logic          trig_pin,
  output logic               sync_en
);

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic        acc;
  logic        wr;
  logic        rd;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= ADDR_DATA);
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  assign acc     = psel & penable & pready_r;
  assign wr      = acc & pwrite & mapped(paddr);
  assign rd      = acc & ~pwrite & mapped(paddr);
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;

  // ****************************************************************
  // pending and active configuration
  // ****************************************************************
  logic [15:0] cnt_pre_p, cnt_post_p, cnt_stop_p, cnt_pre_r, cnt_post_r, cnt_stop_r;
  logic [31:0] ivl_acq_p, ivl_norm_p, ivl_acq_r, ivl_norm_r;
  logic [9:0]  trig_p, trig_r;
  logic [19:0] chan_p;
  logic        chan_pend_r;
  logic        fmt_p, fmt_r;
  logic        exec;

  assign exec    = wr && hit(paddr, ADDR_CTRL) && pwdata[CTRL_EXEC];
  assign sync_en = trig_r[TRG_SYNC];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_pre_p   <= RST_CNT;
      cnt_post_p  <= RST_CNT;
      cnt_stop_p  <= RST_CNT;
      ivl_acq_p   <= RST_WORD;
      ivl_norm_p  <= RST_WORD;
      trig_p      <= '0;
      chan_p      <= '0;
      chan_pend_r <= 1'b0;
      fmt_p       <= FMT_ASCII;
    end else if (wr) begin
      if (hit(paddr, ADDR_CNT_PRE))  cnt_pre_p  <= pwdata[15:0];
      if (hit(paddr, ADDR_CNT_POST)) cnt_post_p <= pwdata[15:0];
      if (hit(paddr, ADDR_CNT_STOP)) cnt_stop_p <= pwdata[15:0];
      if (hit(paddr, ADDR_IVL_ACQ))  ivl_acq_p  <= pwdata;
      if (hit(paddr, ADDR_IVL_NORM)) ivl_norm_p <= pwdata;
      if (hit(paddr, ADDR_TRIG))     trig_p     <= pwdata[9:0];
      if (hit(paddr, ADDR_FMT))      fmt_p      <= pwdata[0];
      if (hit(paddr, ADDR_CHAN)) begin
        chan_p      <= pwdata[19:0];
        chan_pend_r <= 1'b1;
      end else if (exec) begin
        chan_pend_r <= 1'b0;
      end
    end
  end

  // held characters take effect only on execute, except the channel range, which the scan walk uses as soon as it is written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_pre_r  <= RST_CNT;
      cnt_post_r <= RST_CNT;
      cnt_stop_r <= RST_CNT;
      ivl_acq_r  <= RST_WORD;
      ivl_norm_r <= RST_WORD;
      trig_r     <= '0;
      fmt_r      <= FMT_ASCII;
    end else if (exec) begin
      cnt_pre_r  <= cnt_pre_p;
      cnt_post_r <= cnt_post_p;
      cnt_stop_r <= cnt_stop_p;
      ivl_acq_r  <= ivl_acq_p;
      ivl_norm_r <= ivl_norm_p;
      trig_r     <= trig_p;
      fmt_r      <= fmt_p;
    end
  end

  // ****************************************************************
  // channel sensor types
  // ****************************************************************
  logic [3:0] ch_type_r [1:NCH];

  generate
    for (genvar i = 1; i <= NCH; i++) begin : g_ch
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ch_type_r[i] <= 4'h0;
        end else if (exec && chan_pend_r &&
                     (8'(i) >= chan_p[CH_FIRST_LSB +: 8]) &&
                     (8'(i) <= chan_p[CH_LAST_LSB +: 8])) begin
          ch_type_r[i] <= chan_p[CH_TYPE_LSB +: 4];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // trigger pin synchroniser and events
  // ****************************************************************
  logic [2:0] pin_sync_r;
  logic       pin_lvl_r;
  logic       pin_rise;
  logic       trig_char;
  logic       stop_char;
  logic       trig_hit;
  logic       stop_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_r <= 3'b000;
      pin_lvl_r  <= 1'b0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], trig_pin};
      if (pin_sync_r[1] == pin_sync_r[2]) pin_lvl_r <= pin_sync_r[2];
    end
  end

  assign pin_rise  = (pin_sync_r[1] == pin_sync_r[2]) & pin_sync_r[2] & ~pin_lvl_r;
  assign trig_char = wr && hit(paddr, ADDR_CTRL) && pwdata[CTRL_TRIG];
  assign stop_char = wr && hit(paddr, ADDR_CTRL) && pwdata[CTRL_STOP];
  assign trig_hit  = (trig_r[TRG_START_LSB +: 4] == SRC_CHAR && trig_char) ||
                     (trig_r[TRG_START_LSB +: 4] == SRC_PIN && pin_rise);
  assign stop_hit  = (trig_r[TRG_STOP_LSB +: 4] == SRC_CHAR && stop_char) ||
                     (trig_r[TRG_STOP_LSB +: 4] == SRC_PIN && pin_rise);

  // ****************************************************************
  // interval timing
  // ****************************************************************
  function automatic logic [31:0] tenths(input logic [31:0] v);
    tenths = ((32'(v[IVL_HOUR_LSB +: 8]) * 32'd60 + 32'(v[IVL_MIN_LSB +: 6])) * 32'd60
             + 32'(v[IVL_SEC_LSB +: 6])) * 32'd10 + 32'(v[IVL_TENTH_LSB +: 4]);
  endfunction

  tsa_state_t  st_r;
  tsa_scan_t   sc_r;
  logic [31:0] ivl_now;
  logic [47:0] gap_r;
  logic [CW-1:0] ch_idx_r;
  logic        scan_done;
  logic [15:0] scn_cnt_r;
  logic        scanning;

  assign ivl_now   = (st_r == ST_POST) ? tenths(ivl_acq_r) : tenths(ivl_norm_r);
  assign scanning  = (st_r == ST_PRE) || (st_r == ST_POST) || (st_r == ST_PSTOP);
  assign scan_done = (sc_r == SC_REQ) && scan_ack &&
                     (8'(ch_idx_r) >= chan_p[CH_LAST_LSB +: 8]);
  assign scan_req  = (sc_r == SC_REQ);
  assign scan_chan = ch_idx_r;

  // ****************************************************************
  // per-scan channel walk
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_r      <= SC_IDLE;
      ch_idx_r  <= '0;
      scan_type <= 4'h0;
      gap_r     <= '0;
    end else begin
      case (sc_r)
        SC_IDLE: begin
          if (scanning) begin
            ch_idx_r  <= chan_p[CH_FIRST_LSB +: CW];
            scan_type <= ch_type_r[chan_p[CH_FIRST_LSB +: CW]];
            sc_r      <= SC_REQ;
          end
        end
        SC_REQ: begin
          if (scan_done) begin
            gap_r <= 48'(64'(ivl_now) * 64'(TENTH_CYCLES));
            sc_r  <= (ivl_now == 32'd0) ? SC_IDLE : SC_GAP;
          end else if (scan_ack) begin
            ch_idx_r  <= ch_idx_r + 1'b1;
            scan_type <= ch_type_r[ch_idx_r + 1'b1];
          end
        end
        SC_GAP: begin
          if (gap_r <= 48'd1) sc_r <= SC_IDLE;
          gap_r <= gap_r - 48'd1;
        end
        default: sc_r <= SC_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // acquisition state sequence
  // ****************************************************************
  logic [7:0] spoll_r;
  logic [7:0] evt_r;
  logic       done_set;
  logic       post_end;
  logic       pstop_end;
  logic       trig_pend_r;
  logic       trig_go;

  assign post_end  = (trig_r[TRG_STOP_LSB +: 4] == STOP_COUNT) &&
                     ((cnt_post_r == RST_CNT) || (scan_done && scn_cnt_r + 16'd1 >= cnt_post_r));
  assign pstop_end = (cnt_stop_r == RST_CNT) || (scan_done && scn_cnt_r + 16'd1 >= cnt_stop_r);
  assign done_set  = (st_r == ST_PSTOP) && pstop_end;
  // a trigger waits for the scan in flight, so no block opens with a partial scan
  assign trig_go   = (trig_hit || trig_pend_r) && ((sc_r != SC_REQ) || scan_done);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_pend_r <= 1'b0;
    end else if (exec || (st_r != ST_PRE)) begin
      trig_pend_r <= 1'b0;
    end else if (trig_hit) begin
      trig_pend_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= ST_IDLE;
      scn_cnt_r <= RST_CNT;
    end else if (exec) begin
      st_r      <= ST_PRE;
      scn_cnt_r <= RST_CNT;
    end else begin
      case (st_r)
        ST_PRE: begin
          if (trig_go) begin
            st_r      <= ST_POST;
            scn_cnt_r <= RST_CNT;
          end else if (scan_done && scn_cnt_r != 16'hffff) begin
            scn_cnt_r <= scn_cnt_r + 16'd1;
          end
        end
        ST_POST: begin
          if (post_end || stop_hit) begin
            st_r      <= ST_PSTOP;
            scn_cnt_r <= RST_CNT;
          end else if (scan_done) begin
            scn_cnt_r <= scn_cnt_r + 16'd1;
          end
        end
        ST_PSTOP: begin
          if (pstop_end) begin
            st_r <= ST_DONE;
          end else if (scan_done) begin
            scn_cnt_r <= scn_cnt_r + 16'd1;
          end
        end
        ST_DONE: begin
          if (trig_r[TRG_REARM]) begin
            st_r      <= ST_PRE;
            scn_cnt_r <= RST_CNT;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // serial poll: ready after reset, trigger bit cleared on execute, not on rearm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spoll_r <= 8'h00;
    end else begin
      spoll_r[SP_READY] <= 1'b1;
      if (st_r == ST_PRE && trig_hit) begin
        spoll_r[SP_TRIG] <= 1'b1;
      end else if (exec) begin
        spoll_r[SP_TRIG] <= 1'b0;
      end
    end
  end

  // a read clears only the bits it reported; a new completion wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_r <= 8'h00;
    end else if (done_set) begin
      evt_r[EV_ACQ_DONE] <= 1'b1;
    end else if (rd && hit(paddr, ADDR_EVT)) begin
      evt_r <= evt_r & ~prdata_r[7:0];
    end
  end

  // ****************************************************************
  // acquisition buffer
  // ****************************************************************
  tsa_buf_if #(.W(16), .AW(AW)) buf_if ();
  logic [AW:0] wr_ptr_r, rd_ptr_r, rd_lim_r, blk_end_r;
  logic        blk_ok_r;
  logic [AW:0] avail;
  logic        store;
  logic        pop;
  logic        data_rd;
  logic [2:0]  chr_r;

  assign avail = wr_ptr_r - rd_ptr_r;
  assign store = scanning && (sc_r == SC_REQ) && scan_ack && (avail[AW] == 1'b0) &&
                 ((st_r != ST_PRE) || (scn_cnt_r < cnt_pre_r));
  assign data_rd = rd && hit(paddr, ADDR_DATA) && (rd_ptr_r != rd_lim_r);
  assign pop   = data_rd && ((fmt_r != FMT_ASCII) || (chr_r == 3'd7));

  assign buf_if.wr_en   = store;
  assign buf_if.wr_addr = wr_ptr_r[AW-1:0];
  assign buf_if.wr_data = scan_data;
  assign buf_if.rd_addr = rd_ptr_r[AW-1:0];

  tsa_buf_mem #(.W(16), .AW(AW)) u_mem (
    .pclk (pclk),
    .bus  (buf_if)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r  <= '0;
      rd_ptr_r  <= '0;
      rd_lim_r  <= '0;
      blk_end_r <= '0;
      blk_ok_r  <= 1'b0;
      chr_r     <= 3'd0;
    end else if (exec) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      rd_lim_r <= '0;
      blk_ok_r <= 1'b0;
      chr_r    <= 3'd0;
    end else begin
      if (store) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (wr && hit(paddr, ADDR_CTRL) && pwdata[CTRL_RDBLK]) begin
        rd_lim_r <= blk_ok_r ? blk_end_r : rd_ptr_r;
        blk_ok_r <= 1'b0;
        chr_r    <= 3'd0;
      end
      // a block that completes as the last one is claimed stays claimable
      if (done_set) begin
        blk_end_r <= wr_ptr_r + (store ? 1'b1 : 1'b0);
        blk_ok_r  <= 1'b1;
      end
      if (data_rd) chr_r <= (fmt_r == FMT_ASCII) ? chr_r + 3'd1 : 3'd0;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

  // ****************************************************************
  // ascii rendering: sign, four digits, point, tenth, comma
  // ****************************************************************
  function automatic logic [7:0] asc(input logic [15:0] v, input logic [2:0] idx);
    logic [15:0] m;
    m = v[15] ? 16'(-v) : v;
    case (idx)
      3'd0:    asc = v[15] ? 8'h2d : 8'h2b;
      3'd1:    asc = 8'h30 + 8'((m / 16'd10000) % 16'd10);
      3'd2:    asc = 8'h30 + 8'((m / 16'd1000) % 16'd10);
      3'd3:    asc = 8'h30 + 8'((m / 16'd100) % 16'd10);
      3'd4:    asc = 8'h30 + 8'((m / 16'd10) % 16'd10);
      3'd5:    asc = 8'h2e;
      3'd6:    asc = 8'h30 + 8'(m % 16'd10);
      default: asc = 8'h2c;
    endcase
  endfunction

  // ****************************************************************
  // apb answer: one wait state so read data leaves a flip-flop
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= RST_WORD;
    end else begin
      pready_r  <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & ~mapped(paddr);
      if (psel && penable && !pready_r && !pwrite) begin
        case (paddr)
          ADDR_CNT_PRE:  prdata_r <= {16'h0000, cnt_pre_p};
          ADDR_CNT_POST: prdata_r <= {16'h0000, cnt_post_p};
          ADDR_CNT_STOP: prdata_r <= {16'h0000, cnt_stop_p};
          ADDR_IVL_ACQ:  prdata_r <= ivl_acq_p;
          ADDR_IVL_NORM: prdata_r <= ivl_norm_p;
          ADDR_TRIG:     prdata_r <= {22'h000000, trig_p};
          ADDR_CHAN:     prdata_r <= {12'h000, chan_p};
          ADDR_FMT:      prdata_r <= {31'h00000000, fmt_r};
          ADDR_SPOLL:    prdata_r <= {24'h000000, spoll_r};
          ADDR_EVT:      prdata_r <= {24'h000000, evt_r};
          ADDR_BUFST:    prdata_r <= 32'(avail);
          ADDR_DATA: begin
            if (rd_ptr_r == rd_lim_r) prdata_r <= RST_WORD;
            else if (fmt_r != FMT_ASCII) prdata_r <= {16'h0000, buf_if.rd_data};
            else prdata_r <= {24'h000000, asc(buf_if.rd_data, chr_r)};
          end
          default:       prdata_r <= RST_WORD;
        endcase
      end
    end
  end

endmodule

// ### verilog/tsa_buf_if.sv
// reading buffer port between sequencer and its memory
`timescale 1ns/1ns
interface tsa_buf_if #(
  parameter int unsigned W  = 16,
  parameter int unsigned AW = 10
);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [W-1:0]  wr_data;
  logic [AW-1:0] rd_addr;
  logic [W-1:0]  rd_data;

  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ### verilog/tsa_buf_mem.sv
// acquisition buffer memory with registered read data
`timescale 1ns/1ns
module tsa_buf_mem #(
  parameter int unsigned W  = 16,
  parameter int unsigned AW = 10
) (
  input wire logic pclk,
  tsa_buf_if.mem   bus
);
  logic [W-1:0] mem_r [2**AW];

  always_ff @(posedge pclk) begin
    if (bus.wr_en) begin
      mem_r[bus.wr_addr] <= bus.wr_data;
    end
  end

  always_ff @(posedge pclk) begin
    bus.rd_data <= mem_r[bus.rd_addr];
  end
endmodule

// ### verilog/tsa_pkg.sv
// constants and types shared by the triggered scan acquisition block
package tsa_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TENTH_NS      = 100_000_000;
  localparam int unsigned TENTH_CYC     = TENTH_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_CNT_PRE  = 8'h04;
  localparam logic [7:0] ADDR_CNT_POST = 8'h08;
  localparam logic [7:0] ADDR_CNT_STOP = 8'h0c;
  localparam logic [7:0] ADDR_IVL_ACQ  = 8'h10;
  localparam logic [7:0] ADDR_IVL_NORM = 8'h14;
  localparam logic [7:0] ADDR_TRIG     = 8'h18;
  localparam logic [7:0] ADDR_CHAN     = 8'h1c;
  localparam logic [7:0] ADDR_FMT      = 8'h20;
  localparam logic [7:0] ADDR_SPOLL    = 8'h24;
  localparam logic [7:0] ADDR_EVT      = 8'h28;
  localparam logic [7:0] ADDR_BUFST    = 8'h2c;
  localparam logic [7:0] ADDR_DATA     = 8'h30;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned CTRL_EXEC     = 0;
  localparam int unsigned CTRL_TRIG     = 1;
  localparam int unsigned CTRL_STOP     = 2;
  localparam int unsigned CTRL_RDBLK    = 3;
  localparam int unsigned IVL_TENTH_LSB = 0;
  localparam int unsigned IVL_SEC_LSB   = 4;
  localparam int unsigned IVL_MIN_LSB   = 10;
  localparam int unsigned IVL_HOUR_LSB  = 16;
  localparam int unsigned TRG_START_LSB = 0;
  localparam int unsigned TRG_STOP_LSB  = 4;
  localparam int unsigned TRG_REARM     = 8;
  localparam int unsigned TRG_SYNC      = 9;
  localparam int unsigned CH_FIRST_LSB  = 0;
  localparam int unsigned CH_LAST_LSB   = 8;
  localparam int unsigned CH_TYPE_LSB   = 16;
  localparam int unsigned SP_TRIG       = 1;
  localparam int unsigned SP_READY      = 2;
  localparam int unsigned EV_ACQ_DONE   = 0;

  // ****************************************************************
  // source codes and reset values
  // ****************************************************************
  localparam logic [3:0]  SRC_NONE   = 4'h0;
  localparam logic [3:0]  SRC_CHAR   = 4'h1;
  localparam logic [3:0]  SRC_PIN    = 4'h2;
  localparam logic [3:0]  STOP_COUNT = 4'h8;
  localparam logic [15:0] RST_CNT    = 16'h0000;
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
  localparam logic        FMT_ASCII  = 1'b0;

  typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_POST, ST_PSTOP, ST_DONE} tsa_state_t;
  typedef enum logic [1:0] {SC_IDLE, SC_REQ, SC_GAP} tsa_scan_t;

endpackage
